// ==== inc/pstfb_if.sv ====
// Internal carrier between the top and its two engines.
// Assumes all members run on the core clock.
`timescale 1ns/1ps
interface pstfb_if;
    import pstfb_pkg::*;
    // Counter group
    logic active;
    logic perf_tick;
    logic wr_ref;
    logic wr_del;
    pstfb_cnt_t wdata;
    pstfb_cnt_t ref_cnt;
    pstfb_cnt_t del_cnt;
    // Transition group
    logic tgt_wr;
    logic enable;
    pstfb_op_t tgt;
    pstfb_op_t cur;
    logic busy;
    modport ctr_m (output active, perf_tick, wr_ref, wr_del, wdata,
                   input ref_cnt, del_cnt);
    modport ctr_s (input active, perf_tick, wr_ref, wr_del, wdata,
                   output ref_cnt, del_cnt);
    modport trn_m (output tgt_wr, enable, tgt, input cur, busy);
    modport trn_s (input tgt_wr, enable, tgt, output cur, busy);
endinterface

// ==== inc/pstfb_map.svh ====
// Holds addresses, field positions, reset values and timing counts.
// Assumes inclusion by bare name from every design file.
`ifndef PSTFB_MAP_SVH
`define PSTFB_MAP_SVH
// Model register addresses
`define PSTFB_ADR_REF 32'h0000_00E7
`define PSTFB_ADR_DEL 32'h0000_00E8
`define PSTFB_ADR_STAT 32'h0000_0198
`define PSTFB_ADR_TGT 32'h0000_0199
`define PSTFB_ADR_MISC 32'h0000_01A0
// Field positions
`define PSTFB_MISC_EN_BIT 16
`define PSTFB_DIS_BIT 32
`define PSTFB_FEAT_BIT 7
`define PSTFB_FB_BIT 0
// Identification leaves
`define PSTFB_LEAF_FEAT 8'h01
`define PSTFB_LEAF_PWR 8'h06
// Reset values and counter wrap limit
`define PSTFB_OP_RST 16'h0000
`define PSTFB_CNT_RST 64'h0000_0000_0000_0000
`define PSTFB_CNT_MAX 64'hFFFF_FFFF_FFFF_FFFF
// Timing: core clock period and transition settle time
`define PSTFB_CLK_NS 20
`define PSTFB_TRANS_NS 10000
`define PSTFB_TRANS_CYC (`PSTFB_TRANS_NS / `PSTFB_CLK_NS)
`endif

// ==== inc/pstfb_pkg.sv ====
// Types shared by the performance-state and feedback counter block.
// Assumes the map header supplies all numeric constants.
package pstfb_pkg;
    // Operating-point code
    typedef logic [15:0] pstfb_op_t;
    // Feedback counter word
    typedef logic [63:0] pstfb_cnt_t;
    // Transition engine states
    typedef enum logic [0:0] {
        PSTFB_IDLE = 1'b0,
        PSTFB_STEP = 1'b1
    } pstfb_trn_state_t;
endpackage

// ==== sim/pstfb_tb_top.sv ====
// Self-checking bench for the performance-state and feedback counter block.
// Assumes the top module alone, driven straight through its register port.
`timescale 1ns/1ps
`include "pstfb_map.svh"
module pstfb_tb_top
    import pstfb_pkg::*;
;
    // Stimulus
    logic sys_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic msr_req_i = 1'b0;
    logic msr_wr_i = 1'b0;
    logic [31:0] msr_addr_i = 32'h0;
    logic [63:0] msr_wdata_i = 64'h0;
    logic id_req_i = 1'b0;
    logic [7:0] id_leaf_i = 8'h0;
    logic active_i = 1'b0;
    logic perf_tick_i = 1'b0;
    // Observed outputs
    logic msr_ack_o;
    logic msr_fault_o;
    logic [63:0] msr_rdata_o;
    logic [31:0] id_ecx_o;
    logic [15:0] op_point_o;
    logic trans_busy_o;
    logic boost_disengage_o;
    // Bookkeeping
    int mismatches = 0;
    int n_compared = 0;
    int cyc = 0;
    int tcyc;
    int t1;
    int n;
    pstfb_cnt_t rd;
    pstfb_cnt_t rd2;
    logic flt;
    logic [7:0] leaves [3] = '{8'h01, 8'h06, 8'h02};
    logic [31:0] ecx_exp [3] = '{32'h0000_0080, 32'h0000_0001, 32'h0000_0000};

    pstfb_top dut (
        .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
        .msr_req_i(msr_req_i), .msr_wr_i(msr_wr_i), .msr_addr_i(msr_addr_i),
        .msr_wdata_i(msr_wdata_i), .msr_ack_o(msr_ack_o), .msr_fault_o(msr_fault_o),
        .msr_rdata_o(msr_rdata_o), .id_req_i(id_req_i), .id_leaf_i(id_leaf_i),
        .id_ecx_o(id_ecx_o), .active_i(active_i), .perf_tick_i(perf_tick_i),
        .op_point_o(op_point_o), .trans_busy_o(trans_busy_o),
        .boost_disengage_o(boost_disengage_o)
    );

    // 50 MHz core clock
    always #10 sys_clk_i = ~sys_clk_i;

    // Cycle count, used to time counter readings
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
    end

    // Word comparison, every width extended to 64 bits
    task automatic cmp_word(input string what, input logic [63:0] exp, input logic [63:0] got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Single-bit comparison
    task automatic cmp_bit(input string what, input logic exp, input logic got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s expected %b seen %b", what, exp, got);
        end
    endtask

    // One register access: one-cycle request, then wait a few cycles for the answer
    task automatic msr(input logic wr, input logic [31:0] addr, input logic [63:0] wd,
                       output pstfb_cnt_t rdat, output logic fault);
        int k;
        @(posedge sys_clk_i);
        #1;
        msr_req_i = 1'b1;
        msr_wr_i = wr;
        msr_addr_i = addr;
        msr_wdata_i = wd;
        @(posedge sys_clk_i);
        tcyc = cyc;
        #1;
        msr_req_i = 1'b0;
        k = 0;
        while (msr_ack_o !== 1'b1 && k < 4) begin
            @(posedge sys_clk_i);
            #1;
            k++;
        end
        cmp_bit("register answer", 1'b1, msr_ack_o);
        rdat = msr_rdata_o;
        fault = msr_fault_o;
    endtask

    // Write that must be accepted
    task automatic wr(input logic [31:0] addr, input logic [63:0] wd);
        msr(1'b1, addr, wd, rd, flt);
        cmp_bit("write fault", 1'b0, flt);
    endtask

    // Read checked against an expected word and fault flag
    task automatic rdchk(input string what, input logic [31:0] addr, input logic [63:0] exp,
                         input logic expf);
        msr(1'b0, addr, 64'h0, rd, flt);
        cmp_word(what, exp, rd);
        cmp_bit("read fault", expf, flt);
    endtask

    // Wait for an operating point under a bound, then compare it
    task automatic wait_op(input logic [15:0] op, input int lim);
        int k;
        k = 0;
        while (op_point_o !== op && k < lim) begin
            @(posedge sys_clk_i);
            #1;
            k++;
        end
        cmp_word("operating point", {48'h0, op}, {48'h0, op_point_o});
    endtask

    // Length of one busy period, in cycles
    task automatic busy_len(output int len);
        int k;
        k = 0;
        len = 0;
        while (trans_busy_o !== 1'b1 && k < 10) begin
            @(posedge sys_clk_i);
            #1;
            k++;
        end
        while (trans_busy_o === 1'b1 && len < 2000) begin
            @(posedge sys_clk_i);
            #1;
            len++;
        end
    endtask

    // Verdict and end of run
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Watchdog, well beyond the few thousand cycles the tests need
    initial begin
        #400000;
        mismatches++;
        report_and_stop();
    end

    // Main sequence
    initial begin
        repeat (6) @(posedge sys_clk_i);
        #1;
        rst_b_i = 1'b1;
        repeat (3) @(posedge sys_clk_i);
        #1;
        // Reset state and refused address
        cmp_bit("busy after reset", 1'b0, trans_busy_o);
        rdchk("enable register", `PSTFB_ADR_MISC, 64'h0, 1'b0);
        rdchk("reference count", `PSTFB_ADR_REF, `PSTFB_CNT_RST, 1'b0);
        rdchk("unmapped read", 32'h0000_0010, 64'h0, 1'b1);
        // Identification leaves, including one that reports nothing
        for (int i = 0; i < 3; i++) begin
            @(posedge sys_clk_i);
            #1;
            id_req_i = 1'b1;
            id_leaf_i = leaves[i];
            @(posedge sys_clk_i);
            #1;
            id_req_i = 1'b0;
            @(posedge sys_clk_i);
            #1;
            cmp_word("ident answer", {32'h0, ecx_exp[i]}, {32'h0, id_ecx_o});
        end
        // Target written while disabled is held back
        wr(`PSTFB_ADR_TGT, 64'h0000_0000_0000_0A05);
        repeat (20) @(posedge sys_clk_i);
        #1;
        cmp_bit("busy while disabled", 1'b0, trans_busy_o);
        rdchk("target readback", `PSTFB_ADR_TGT, 64'h0A05, 1'b0);
        // Enable keeps only its own bit, then the held target starts
        wr(`PSTFB_ADR_MISC, 64'hFFFF_FFFF_FFFF_FFFF);
        rdchk("enable register", `PSTFB_ADR_MISC, 64'h0000_0000_0001_0000, 1'b0);
        wait_op(16'h0000, 1);
        cmp_bit("busy after enable", 1'b1, trans_busy_o);
        // Newer target with disengage bit during the step
        wr(`PSTFB_ADR_TGT, 64'h0000_0001_0000_0B07);
        rdchk("target readback", `PSTFB_ADR_TGT, 64'h0000_0001_0000_0B07, 1'b0);
        rdchk("status mid step", `PSTFB_ADR_STAT, 64'h0, 1'b0);
        wait_op(16'h0A05, 600);
        wait_op(16'h0B07, 1200);
        rdchk("status", `PSTFB_ADR_STAT, 64'h0B07, 1'b0);
        cmp_bit("disengage", 1'b1, boost_disengage_o);
        // Status register ignores writes
        busy_len(n);
        wr(`PSTFB_ADR_STAT, 64'h0123);
        repeat (5) @(posedge sys_clk_i);
        #1;
        cmp_word("point after status write", 64'h0B07, {48'h0, op_point_o});
        cmp_bit("busy after status write", 1'b0, trans_busy_o);
        // One plain step and its length
        wr(`PSTFB_ADR_TGT, 64'h0C03);
        busy_len(n);
        cmp_word("step length", 64'd500, 64'(n));
        wait_op(16'h0C03, 5);
        cmp_bit("disengage", 1'b0, boost_disengage_o);
        // Counters written independently and frozen while inactive
        wr(`PSTFB_ADR_REF, 64'h1234);
        wr(`PSTFB_ADR_DEL, 64'hABCD);
        rdchk("reference count", `PSTFB_ADR_REF, 64'h1234, 1'b0);
        rdchk("delivered count", `PSTFB_ADR_DEL, 64'hABCD, 1'b0);
        // Active without ticks: reference moves, delivered does not
        active_i = 1'b1;
        repeat (4) @(posedge sys_clk_i);
        msr(1'b0, `PSTFB_ADR_REF, 64'h0, rd, flt);
        t1 = tcyc;
        msr(1'b0, `PSTFB_ADR_REF, 64'h0, rd2, flt);
        cmp_word("reference rate", rd + 64'(tcyc - t1), rd2);
        msr(1'b0, `PSTFB_ADR_DEL, 64'h0, rd, flt);
        msr(1'b0, `PSTFB_ADR_DEL, 64'h0, rd2, flt);
        cmp_word("delivered idle", rd, rd2);
        // Ticks every cycle: delivered follows the clock
        perf_tick_i = 1'b1;
        msr(1'b0, `PSTFB_ADR_DEL, 64'h0, rd, flt);
        t1 = tcyc;
        msr(1'b0, `PSTFB_ADR_DEL, 64'h0, rd2, flt);
        cmp_word("delivered rate", rd + 64'(tcyc - t1), rd2);
        // Either counter wrapping clears both, which then run on together
        for (int i = 0; i < 2; i++) begin
            wr(i == 0 ? `PSTFB_ADR_REF : `PSTFB_ADR_DEL, `PSTFB_CNT_MAX - 64'h5);
            repeat (20) @(posedge sys_clk_i);
            msr(1'b0, `PSTFB_ADR_REF, 64'h0, rd, flt);
            t1 = tcyc;
            msr(1'b0, `PSTFB_ADR_DEL, 64'h0, rd2, flt);
            cmp_bit("cleared after wrap", 1'b1, rd < 64'd40);
            cmp_word("pair after wrap", rd + 64'(tcyc - t1), rd2);
        end
        // Inactive again: reference stands still
        active_i = 1'b0;
        repeat (4) @(posedge sys_clk_i);
        msr(1'b0, `PSTFB_ADR_REF, 64'h0, rd, flt);
        msr(1'b0, `PSTFB_ADR_REF, 64'h0, rd2, flt);
        cmp_word("reference inactive", rd, rd2);
        // Window start: each counter zeroed on its own
        wr(`PSTFB_ADR_REF, `PSTFB_CNT_RST);
        wr(`PSTFB_ADR_DEL, `PSTFB_CNT_RST);
        rdchk("reference zeroed", `PSTFB_ADR_REF, `PSTFB_CNT_RST, 1'b0);
        rdchk("delivered zeroed", `PSTFB_ADR_DEL, `PSTFB_CNT_RST, 1'b0);
        report_and_stop();
    end
endmodule

// ==== src/pstfb_counters.sv ====
// Pair of 64-bit feedback counters for one logical processor.
// Assumes active is already synchronised to the core clock.
`timescale 1ns/1ps
`include "pstfb_map.svh"
module pstfb_counters
    import pstfb_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Carrier
    pstfb_if.ctr_s cif
);
    // Increment conditions
    wire logic ref_inc = cif.active;
    wire logic del_inc = cif.active & cif.perf_tick;
    // Wrap of either counter
    wire logic ref_wrap = ref_inc & (cif.ref_cnt == `PSTFB_CNT_MAX);
    wire logic del_wrap = del_inc & (cif.del_cnt == `PSTFB_CNT_MAX);
    wire logic any_wrap = ref_wrap | del_wrap;
    // Next values, write wins per counter
    wire pstfb_cnt_t next_ref = cif.wr_ref ? cif.wdata :
        any_wrap ? `PSTFB_CNT_RST : cif.ref_cnt + {63'h0, ref_inc};
    wire pstfb_cnt_t next_del = cif.wr_del ? cif.wdata :
        any_wrap ? `PSTFB_CNT_RST : cif.del_cnt + {63'h0, del_inc};

    // Counter registers
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cif.ref_cnt <= `PSTFB_CNT_RST;
            cif.del_cnt <= `PSTFB_CNT_RST;
        end else begin
            cif.ref_cnt <= next_ref;
            cif.del_cnt <= next_del;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // Wrap clears both
    wrap_clears_both_a: assert property (
        any_wrap && !cif.wr_ref && !cif.wr_del |=> cif.ref_cnt == 0 && cif.del_cnt == 0)
        else $error("wrap did not clear both counters");
    // Idle keeps counters
    idle_holds_a: assert property (
        !cif.active && !cif.wr_ref && !cif.wr_del |=> $stable(cif.ref_cnt)
        && $stable(cif.del_cnt))
        else $error("counter moved outside active state");
    wrap_seen_c: cover property (any_wrap);
endmodule

// ==== src/pstfb_top.sv ====
// Performance-state control and hardware-coordination feedback counters.
// Assumes a model register port on the core clock; active pin is async.
// Function
// - Identification reports performance-state support bit seven
// - Mechanism runs only while enable bit set; a step already running still completes after it clears
// - Writing target register starts a transition
// - Target written mid-transition is applied afterwards
// - Target read returns last requested point
// - Status shows point in effect, updated live
// - Point codes are implementation specific, software-reserved
// - Each transition is one discrete frequency step
// - Leaf six reports feedback counters present
// - Reference counter ticks at fixed rate
// - Delivered counter tracks throttled actual performance
// - Per-processor pair, counting only when active
// - Either counter wrapping clears both
// - Full 64-bit counters, independently writable
// - Disengage bit absent from status, unshared
`timescale 1ns/1ps
`include "pstfb_map.svh"
module pstfb_top
    import pstfb_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    // Model register port
    input wire logic msr_req_i,
    input wire logic msr_wr_i,
    input wire logic [31:0] msr_addr_i,
    input wire logic [63:0] msr_wdata_i,
    output logic msr_ack_o,
    output logic msr_fault_o,
    output logic [63:0] msr_rdata_o,
    // Identification query
    input wire logic id_req_i,
    input wire logic [7:0] id_leaf_i,
    output logic [31:0] id_ecx_o,
    // Processor state and throttling
    input wire logic active_i,
    input wire logic perf_tick_i,
    // Operating point to clock and voltage logic
    output logic [15:0] op_point_o,
    output logic trans_busy_o,
    output logic boost_disengage_o
);
    // Reset release synchroniser
    logic rst_s1; // First stage
    logic rst_n; // Released reset used everywhere

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_s1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n <= rst_s1;
        end
    end

    // Active-state pin synchroniser
    logic act_s1; // First stage, read only by act_s2
    logic act_s2; // Synchronised active state

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            act_s1 <= 1'b0;
            act_s2 <= 1'b0;
        end else begin
            act_s1 <= active_i;
            act_s2 <= act_s1;
        end
    end

    // Software-visible state
    logic misc_en; // Mechanism enable
    pstfb_op_t tgt; // Last requested point
    logic dis; // Boost disengage, this processor only

    // Carrier to the engines
    pstfb_if bus_if ();

    // Address decode
    wire logic hit_ref = (msr_addr_i == `PSTFB_ADR_REF);
    wire logic hit_del = (msr_addr_i == `PSTFB_ADR_DEL);
    wire logic hit_stat = (msr_addr_i == `PSTFB_ADR_STAT);
    wire logic hit_tgt = (msr_addr_i == `PSTFB_ADR_TGT);
    wire logic hit_misc = (msr_addr_i == `PSTFB_ADR_MISC);
    wire logic hit_any = hit_ref | hit_del | hit_stat | hit_tgt | hit_misc;
    // Write strobes
    wire logic wr = msr_req_i & msr_wr_i;
    wire logic wr_ref = wr & hit_ref;
    wire logic wr_del = wr & hit_del;
    wire logic wr_tgt = wr & hit_tgt;
    wire logic wr_misc = wr & hit_misc;

    // Read views
    wire logic [63:0] tgt_view = {31'h0, dis, 16'h0000, tgt};
    wire logic [63:0] stat_view = {48'h0, bus_if.cur};
    wire logic [63:0] misc_view = 64'(misc_en) << `PSTFB_MISC_EN_BIT;
    // Read mux
    wire logic [63:0] rd_mux =
        hit_ref ? bus_if.ref_cnt :
        hit_del ? bus_if.del_cnt :
        hit_stat ? stat_view :
        hit_tgt ? tgt_view :
        hit_misc ? misc_view : 64'h0;

    // Control register writes; status has no write path
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            misc_en <= 1'b0;
            tgt <= `PSTFB_OP_RST;
            dis <= 1'b0;
        end else begin
            if (wr_misc) begin
                misc_en <= msr_wdata_i[`PSTFB_MISC_EN_BIT];
            end
            if (wr_tgt) begin
                tgt <= msr_wdata_i[15:0];
                dis <= msr_wdata_i[`PSTFB_DIS_BIT];
            end
        end
    end

    // Register port answer, one cycle after request
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            msr_ack_o <= 1'b0;
            msr_fault_o <= 1'b0;
            msr_rdata_o <= 64'h0;
        end else begin
            msr_ack_o <= msr_req_i;
            msr_fault_o <= msr_req_i & ~hit_any;
            // Read data only for reads, else zero
            msr_rdata_o <= (msr_req_i & ~msr_wr_i) ? rd_mux : 64'h0;
        end
    end

    // Identification answer
    wire logic [31:0] ecx_feat = 32'h1 << `PSTFB_FEAT_BIT;
    wire logic [31:0] ecx_pwr = 32'h1 << `PSTFB_FB_BIT;
    wire logic [31:0] ecx_sel =
        (id_leaf_i == `PSTFB_LEAF_FEAT) ? ecx_feat :
        (id_leaf_i == `PSTFB_LEAF_PWR) ? ecx_pwr : 32'h0;

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            id_ecx_o <= 32'h0;
        end else if (id_req_i) begin
            id_ecx_o <= ecx_sel;
        end
    end

    // Carrier drive
    assign bus_if.active = act_s2;
    assign bus_if.perf_tick = perf_tick_i;
    assign bus_if.wr_ref = wr_ref;
    assign bus_if.wr_del = wr_del;
    assign bus_if.wdata = msr_wdata_i;
    assign bus_if.tgt_wr = wr_tgt;
    // Stored target, so a held or pending request survives later bus traffic
    assign bus_if.tgt = tgt;
    assign bus_if.enable = misc_en;

    // Feedback counter pair
    pstfb_counters u_ctr (
        .clk_i(sys_clk_i),
        .rst_n_i(rst_n),
        .cif(bus_if.ctr_s)
    );

    // Transition engine
    pstfb_transition u_trn (
        .clk_i(sys_clk_i),
        .rst_n_i(rst_n),
        .tif(bus_if.trn_s)
    );

    // Registered copies for the pins
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            op_point_o <= `PSTFB_OP_RST;
            trans_busy_o <= 1'b0;
            boost_disengage_o <= 1'b0;
        end else begin
            op_point_o <= bus_if.cur;
            trans_busy_o <= bus_if.busy;
            boost_disengage_o <= dis;
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n);
    // Identification bits
    feat_bit_a: assert property (
        id_req_i && id_leaf_i == `PSTFB_LEAF_FEAT |=> id_ecx_o[`PSTFB_FEAT_BIT])
        else $error("feature bit missing");
    fb_bit_a: assert property (
        id_req_i && id_leaf_i == `PSTFB_LEAF_PWR |=> id_ecx_o[`PSTFB_FB_BIT])
        else $error("feedback bit missing");
    // Disabled engine never starts
    no_start_dis_a: assert property (
        !misc_en && !bus_if.busy |=> !bus_if.busy)
        else $error("transition while disabled");
    // Target readback is the requested value
    tgt_read_a: assert property (
        msr_req_i && !msr_wr_i && hit_tgt |=>
        msr_rdata_o[15:0] == $past(tgt))
        else $error("target readback wrong");
    // Status write leaves point unchanged
    stat_ro_a: assert property (
        wr && hit_stat && !bus_if.busy |=> $stable(bus_if.cur))
        else $error("status write changed point");
    // Disengage never in status
    dis_hidden_a: assert property (
        msr_req_i && !msr_wr_i && hit_stat |=> msr_rdata_o[`PSTFB_DIS_BIT] == 1'b0)
        else $error("disengage leaked to status");
    // Enabled write starts a step within two cycles
    start_step_a: assert property (
        wr_tgt && misc_en && !bus_if.busy |=> ##[0:1] bus_if.busy)
        else $error("transition not started");
    // Pin follows point one cycle later
    pin_follow_a: assert property (
        1'b1 |=> op_point_o == $past(bus_if.cur))
        else $error("operating point pin stale");
    // Counter write takes value
    ctr_write_a: assert property (
        wr_ref && !wr_del |=> bus_if.ref_cnt == $past(msr_wdata_i))
        else $error("counter write lost");
    // Target stored from the write
    tgt_store_a: assert property (
        wr_tgt |=> tgt == $past(msr_wdata_i[15:0]))
        else $error("target not stored");

    // Disengage stored with the target
    dis_store_a: assert property (
        wr_tgt |=> dis == $past(msr_wdata_i[`PSTFB_DIS_BIT]))
        else $error("disengage not stored");

    // Enable bit taken from its own position
    misc_store_a: assert property (
        wr_misc |=> misc_en == $past(msr_wdata_i[`PSTFB_MISC_EN_BIT]))
        else $error("enable bit not stored");

    // Enable register reads back only its bit
    misc_read_a: assert property (
        msr_req_i && !msr_wr_i && hit_misc |=>
        msr_rdata_o == (64'($past(misc_en)) << `PSTFB_MISC_EN_BIT))
        else $error("enable register readback wrong");

    // Status read shows the point in effect only
    stat_read_a: assert property (
        msr_req_i && !msr_wr_i && hit_stat |=> msr_rdata_o == {48'h0, $past(bus_if.cur)})
        else $error("status readback wrong");

    // Status write answered without fault
    stat_ack_a: assert property (
        wr && hit_stat |=> msr_ack_o && !msr_fault_o)
        else $error("status write refused");

    // Busy pin follows the engine
    busy_pin_a: assert property (
        1'b1 |=> trans_busy_o == $past(bus_if.busy))
        else $error("busy pin stale");

    // Point moves only at the end of a step
    point_idle_a: assert property (
        !bus_if.busy |=> $stable(bus_if.cur))
        else $error("point moved without a step");

    // Reference read returns the count
    ref_read_a: assert property (
        msr_req_i && !msr_wr_i && hit_ref |=> msr_rdata_o == $past(bus_if.ref_cnt))
        else $error("reference readback wrong");

    // Delivered write takes value
    del_write_a: assert property (
        wr_del && !wr_ref |=> bus_if.del_cnt == $past(msr_wdata_i))
        else $error("delivered write lost");

    // Reference advances once per active cycle
    ref_rate_a: assert property (
        bus_if.active && !wr_ref && !wr_del && bus_if.ref_cnt != `PSTFB_CNT_MAX
        && bus_if.del_cnt != `PSTFB_CNT_MAX |=> bus_if.ref_cnt == $past(bus_if.ref_cnt) + 64'h1)
        else $error("reference rate wrong");

    // Delivered holds without a tick
    del_hold_a: assert property (
        bus_if.active && !bus_if.perf_tick && !wr_del && bus_if.ref_cnt != `PSTFB_CNT_MAX
        |=> $stable(bus_if.del_cnt))
        else $error("delivered moved without tick");

    // Other leaves report nothing
    id_other_a: assert property (
        id_req_i && id_leaf_i != `PSTFB_LEAF_FEAT && id_leaf_i != `PSTFB_LEAF_PWR
        |=> id_ecx_o == 32'h0)
        else $error("unexpected identification bits");

    // Main scenarios
    trans_done_c: cover property (bus_if.busy ##1 !bus_if.busy);
    ctr_read_c: cover property (msr_req_i && !msr_wr_i && hit_del);
    fault_c: cover property (msr_fault_o);
endmodule

// ==== src/pstfb_transition.sv ====
// Transition engine: steps the operating point to the latest target.
// Assumes tgt holds the last written target and tgt_wr pulses per write.
`timescale 1ns/1ps
`include "pstfb_map.svh"
module pstfb_transition
    import pstfb_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Carrier
    pstfb_if.trn_s tif
);
    localparam int TRANS_CYC = `PSTFB_TRANS_CYC;
    pstfb_trn_state_t state; // Engine state
    logic pend; // Target waiting to be applied
    pstfb_op_t goal; // Target of running step
    logic [15:0] cnt; // Settle countdown
    // Start when idle, enabled and a target waits
    wire logic start = (state == PSTFB_IDLE) & pend & tif.enable;
    wire logic done = (state == PSTFB_STEP) & (cnt == 16'h0000);
    // Set wins over the clear taken at start
    wire logic next_pend = tif.tgt_wr | (pend & ~start);

    // State, pending and countdown
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= PSTFB_IDLE;
            pend <= 1'b0;
            goal <= `PSTFB_OP_RST;
            cnt <= 16'h0000;
        end else begin
            pend <= next_pend;
            unique case (state)
                PSTFB_IDLE: begin
                    // Latch newest target
                    if (start) begin
                        state <= PSTFB_STEP;
                        goal <= tif.tgt;
                        cnt <= 16'(TRANS_CYC - 1);
                    end
                end
                PSTFB_STEP: begin
                    // Count down, then apply
                    if (done) begin
                        state <= PSTFB_IDLE;
                    end else begin
                        cnt <= cnt - 16'h0001;
                    end
                end
            endcase
        end
    end

    // Operating point changes in one discrete step
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tif.cur <= `PSTFB_OP_RST;
        end else if (done) begin
            tif.cur <= goal;
        end
    end
    assign tif.busy = (state == PSTFB_STEP);

    // Cycles spent in the running step, for the length check only
    logic [15:0] age;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            age <= 16'h0000;
        end else if (start) begin
            age <= 16'h0000;
        end else if (tif.busy) begin
            age <= age + 16'h0001;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // Step length exact
    step_length_a: assert property (
        start |-> ##[1:TRANS_CYC] (done && age == 16'(TRANS_CYC - 1)))
        else $error("transition length wrong");
    // Write during step is applied next
    newer_target_a: assert property (
        tif.busy && tif.tgt_wr |=> pend)
        else $error("newer target dropped");
    back_to_back_c: cover property (tif.busy && tif.tgt_wr);
endmodule
